// File: testbench/tb.sv
// self-checking bench for the post-divider and frame pulse block
`timescale 1ns/1ps
module tb;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic div_c_clk_i = 1'b0;
  logic div_d_clk_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic out_a_o;
  logic out_b_o;
  logic [2:0] rel_cnt = 3'h0;
  int fails = 0;
  int samples_checked = 0;
  spfp_top uut (
    .mclk_i(mclk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .div_c_clk_i(div_c_clk_i), .div_d_clk_i(div_d_clk_i),
    .reg_rdata_o(reg_rdata_o), .out_a_o(out_a_o), .out_b_o(out_b_o)
  );
  always #2.5 mclk_i = ~mclk_i;
  // related clocks: c has a period of 8 cycles, d of 4
  always @(negedge mclk_i)
  begin
    rel_cnt <= rel_cnt + 3'h1;
    div_c_clk_i <= rel_cnt[2];
    div_d_clk_i <= rel_cnt[1];
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
  begin
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
  begin
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge mclk_i);
    reg_rd_i = 1'b0;
    check({24'h00_0000, reg_rdata_o}, {24'h00_0000, exp});
  end
  endtask
  // a ratio spans three bytes, most significant byte first
  task automatic reg24(input logic [7:0] a, input logic [23:0] v);
  begin
    wr(a, v[23:16]);
    wr(a + 8'h01, v[15:8]);
    wr(a + 8'h02, v[7:0]);
    rd(a, v[23:16]);
    rd(a + 8'h01, v[15:8]);
    rd(a + 8'h02, v[7:0]);
  end
  endtask
  task automatic t_reset();
  begin
    check({30'h0, out_a_o, out_b_o}, 32'h0000_0000);
    wr(8'haa, 8'h5a);
    for (logic [7:0] a = 8'ha4; a < 8'hab; a++)
    begin
      rd(a, 8'h00);
    end
    $display("reset and map test done");
  end
  endtask
  // counts high cycles and rises over 160 cycles; lv_exp 2 or hi_exp -1 skip
  task automatic run(input logic [23:0] va, input logic [23:0] vb,
    input logic use_b, input int hi_exp, input int rs_exp, input int lv_exp);
    int hi;
    int rs;
    logic lv;
    logic prev;
    logic cur;
  begin
    reg24(spfp_pkg::ADDR_DIV_A, va);
    reg24(spfp_pkg::ADDR_DIV_B, vb);
    repeat (120) @(posedge mclk_i);
    #1;
    prev = use_b ? out_b_o : out_a_o;
    hi = 0;
    rs = 0;
    lv = 1'bx;
    repeat (160)
    begin
      @(posedge mclk_i);
      #1;
      cur = use_b ? out_b_o : out_a_o;
      if (cur === 1'b1)
        hi++;
      if (cur === 1'b1 && prev === 1'b0)
      begin
        rs++;
        lv = div_c_clk_i;
      end
      prev = cur;
    end
    if (hi_exp >= 0)
      check(32'(hi), 32'(hi_exp));
    check(32'(rs), 32'(rs_exp));
    if (lv_exp < 2)
      check({31'h0, lv}, 32'(lv_exp));
    $display("output test done for %h %h", va, vb);
  end
  endtask
  task automatic test_done();
  begin
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // clock mode ratios, including ratio 1 below the minimum of two
  task automatic t_clock();
  begin
    run(24'h00_0004, 24'h00_0005, 1'b0, 80, 40, 2);
    run(24'h00_0005, 24'h00_0004, 1'b1, 80, 40, 2);
    run(24'h00_0005, 24'h00_0003, 1'b0, 64, 32, 2);
    run(24'h00_0001, 24'h00_0003, 1'b0, 0, 0, 2);
  end
  endtask
  task automatic t_frame_b();
  begin
    run(24'h00_0008, 24'hfa_0004, 1'b1, 40, 5, 1);
    run(24'h00_0008, 24'hfe_0004, 1'b1, 120, 5, 1);
    run(24'h00_0008, 24'hf2_0004, 1'b1, 40, 5, 0);
    run(24'h00_0008, 24'hfb_0004, 1'b1, 40, 10, 2);
    run(24'h00_0008, 24'hf8_0004, 1'b1, 40, 5, 2);
  end
  endtask
  task automatic t_frame_a();
  begin
    run(24'hf9_0004, 24'h00_0004, 1'b0, 40, 10, 2);
    run(24'hfa_0004, 24'h00_0004, 1'b0, 40, 5, 1);
    run(24'hfb_0004, 24'h00_0004, 1'b0, 40, 10, 2);
    run(24'hf2_0004, 24'h00_0004, 1'b0, 40, 5, 0);
  end
  endtask
  // zero period and the reserved select codes
  task automatic t_limits();
  begin
    run(24'h00_0008, 24'hfa_0000, 1'b1, 160, 0, 2);
    run(24'h00_0008, 24'hf9_0004, 1'b1, -1, 0, 2);
    run(24'hf8_0004, 24'h00_0004, 1'b0, -1, 0, 2);
  end
  endtask
  initial
  begin
    repeat (5) @(negedge mclk_i);
    srst_i = 1'b0;
    t_reset();
    t_clock();
    t_frame_b();
    t_frame_a();
    t_limits();
    test_done();
  end
endmodule // tb

// File: verilog/spfp_pkg.sv
// constants for the synthesizer post-divider and frame pulse block
package spfp_pkg;
  localparam int unsigned RATIO_W = 24;
  localparam int unsigned PERIOD_W = 16;
  localparam logic [7:0] ADDR_DIV_A = 8'ha4;
  localparam logic [7:0] ADDR_DIV_B = 8'ha7;
  localparam logic [23:0] RATIO_RESET = 24'h00_0000;
  localparam int unsigned MODE_MSB = 23;
  localparam int unsigned MODE_LSB = 20;
  localparam logic [3:0] MODE_FRAME = 4'hf;
  localparam int unsigned STYLE_BIT = 19;
  localparam int unsigned POL_BIT = 18;
  localparam int unsigned SEL_MSB = 17;
  localparam int unsigned SEL_LSB = 16;
  localparam int unsigned PERIOD_MSB = 15;
  localparam logic [23:0] MAX_RATIO = 24'hef_ffff;
  localparam logic [23:0] MIN_RATIO = 24'h00_0002;
  localparam logic [1:0] SEL_A = 2'h0;
  localparam logic [1:0] SEL_B = 2'h1;
  localparam logic [1:0] SEL_C = 2'h2;
  localparam logic [1:0] SEL_D = 2'h3;
endpackage

// File: verilog/spfp_top.sv
// post-dividers a and b of the third synthesizer with frame pulse shaping
`timescale 1ns/1ps
module spfp_top (
  input wire logic mclk_i, // oscillator clock
  input wire logic srst_i, // synchronous reset, active high
  input wire logic [7:0] reg_addr_i, // register byte address
  input wire logic [7:0] reg_wdata_i, // write byte
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  input wire logic div_c_clk_i, // divider c clock level
  input wire logic div_d_clk_i, // divider d clock level
  output logic [7:0] reg_rdata_o, // read byte, valid after read
  output logic out_a_o, // divider a output
  output logic out_b_o // divider b output
);
  logic [1:0][23:0] ratio;
  logic [1:0][23:0] next_ratio;
  logic [1:0][23:0] div_cnt;
  logic [1:0][23:0] next_div_cnt;
  logic [1:0] div_clk;
  logic [1:0] next_div_clk;
  logic [1:0][15:0] frm_cnt;
  logic [1:0][15:0] next_frm_cnt;
  logic [1:0] pulse;
  logic [1:0] next_pulse;
  logic [3:0] rel_prev;
  logic [3:0] rel_now;
  logic [7:0] next_rdata;
  logic [1:0] next_out;
  logic [1:0] frame;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0][15:0] last;

  // counter step with wrap at limit
  function automatic logic [23:0] spfp_step(input logic [23:0] cnt,
                                            input logic [23:0] limit);
    spfp_step = (cnt >= limit) ? 24'h00_0000 : cnt + 24'h00_0001;
  endfunction

  // byte lane of a 24-bit register, lane 0 is the top byte
  function automatic logic [7:0] spfp_lane(input logic [23:0] r,
                                           input logic [1:0] lane);
    unique case (lane)
      2'h0: spfp_lane = r[23:16];
      2'h1: spfp_lane = r[15:8];
      default: spfp_lane = r[7:0];
    endcase
  endfunction

  assign rel_now = {div_d_clk_i, div_c_clk_i, div_clk};

  always_comb
  begin
    logic [7:0] off;
    logic [1:0] sel;
    logic [23:0] r;
    off = 8'h00;
    sel = 2'h0;
    r = 24'h00_0000;
    next_ratio = ratio;
    next_rdata = 8'h00;
    for (int i = 0; i < 2; i++)
    begin
      off = reg_addr_i - (i == 0 ? spfp_pkg::ADDR_DIV_A
                                 : spfp_pkg::ADDR_DIV_B);
      if (off < 8'h03)
      begin
        if (reg_rd_i)
          next_rdata = spfp_lane(ratio[i], off[1:0]);
        if (reg_wr_i)
        begin
          unique case (off[1:0])
            2'h0: next_ratio[i][23:16] = reg_wdata_i;
            2'h1: next_ratio[i][15:8] = reg_wdata_i;
            default: next_ratio[i][7:0] = reg_wdata_i;
          endcase
        end
      end
    end
    for (int i = 0; i < 2; i++)
    begin
      r = ratio[i];
      frame[i] = r[spfp_pkg::MODE_MSB:spfp_pkg::MODE_LSB]
                 == spfp_pkg::MODE_FRAME;
      // (ratios below two hold the clock low)
      if (r < spfp_pkg::MIN_RATIO)
      begin
        next_div_cnt[i] = 24'h00_0000;
        next_div_clk[i] = 1'b0;
      end
      else
      begin
        next_div_cnt[i] = spfp_step(div_cnt[i], r - 24'h00_0001);
        next_div_clk[i] = next_div_cnt[i] < (r >> 1);
      end
      sel = r[spfp_pkg::SEL_MSB:spfp_pkg::SEL_LSB];
      // own index is the reserved code for each divider
      rise[i] = (sel != 2'(i)) && rel_now[sel] && !rel_prev[sel];
      fall[i] = (sel != 2'(i)) && !rel_now[sel] && rel_prev[sel];
      last[i] = (r[spfp_pkg::PERIOD_MSB:0] == 16'h0000) ? 16'h0000
                : r[spfp_pkg::PERIOD_MSB:0] - 16'h0001;
      next_frm_cnt[i] = frm_cnt[i];
      next_pulse[i] = pulse[i];
      if (frame[i] && rise[i])
      begin
        next_frm_cnt[i] = 16'(spfp_step({8'h00, frm_cnt[i]},
                                        {8'h00, last[i]}));
        if (r[spfp_pkg::STYLE_BIT])
          next_pulse[i] = next_frm_cnt[i] == 16'h0000;
      end
      if (frame[i] && fall[i] && !r[spfp_pkg::STYLE_BIT])
        next_pulse[i] = frm_cnt[i] == last[i];
      next_out[i] = frame[i] ? next_pulse[i] ^ r[spfp_pkg::POL_BIT]
                             : next_div_clk[i];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      ratio <= {2{spfp_pkg::RATIO_RESET}};
      div_cnt <= '0;
      div_clk <= 2'b00;
      frm_cnt <= '0;
      pulse <= 2'b00;
      rel_prev <= 4'h0;
      reg_rdata_o <= 8'h00;
      out_a_o <= 1'b0;
      out_b_o <= 1'b0;
    end
    else
    begin
      ratio <= next_ratio;
      div_cnt <= next_div_cnt;
      div_clk <= next_div_clk;
      frm_cnt <= next_frm_cnt;
      pulse <= next_pulse;
      rel_prev <= rel_now;
      reg_rdata_o <= next_rdata;
      out_a_o <= next_out[0];
      out_b_o <= next_out[1];
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  property p_frame_out;
    frame[0] && $past(frame[0]) && $stable(ratio[0])
      |-> out_a_o == (pulse[0] ^ ratio[0][spfp_pkg::POL_BIT]);
  endproperty
  a_frame_out: assert property (p_frame_out)
    else $error("frame output does not follow pulse");

  property p_clock_out;
    !frame[1] && $past(!frame[1]) |-> out_b_o == div_clk[1];
  endproperty
  a_clock_out: assert property (p_clock_out)
    else $error("clock mode output does not follow divider");

  // looks back over one whole period so a ratio write cannot cut it
  property p_div_four;
    ratio[0] == 24'h00_0004 && $past(ratio[0]) == 24'h00_0004
      && $past(ratio[0], 2) == 24'h00_0004
      && $past(ratio[0], 3) == 24'h00_0004
      && $past(ratio[0], 4) == 24'h00_0004
      && div_cnt[0] == 24'h00_0003 && $past(div_cnt[0], 3) == 24'h00_0000
      |-> $past(div_clk[0], 3) && $past(div_clk[0], 2)
      && !$past(div_clk[0]) && !div_clk[0];
  endproperty
  a_div_four: assert property (p_div_four)
    else $error("divide by four is not two high two low");

  property p_period_wrap;
    frame[0] && rise[0] && frm_cnt[0] >= last[0] && $stable(ratio[0])
      |=> frm_cnt[0] == 16'h0000;
  endproperty
  a_period_wrap: assert property (p_period_wrap)
    else $error("frame counter missed its wrap");

  property p_sel_c;
    frame[1] && ratio[1][17:16] == spfp_pkg::SEL_C && div_c_clk_i
      && !rel_prev[2] && frm_cnt[1] < last[1]
      |=> frm_cnt[1] == $past(frm_cnt[1]) + 16'h0001;
  endproperty
  a_sel_c: assert property (p_sel_c)
    else $error("divider b did not count divider c edge");

  property p_reserved_a;
    frame[0] && ratio[0][17:16] == spfp_pkg::SEL_A |=> $stable(frm_cnt[0]);
  endproperty
  a_reserved_a: assert property (p_reserved_a)
    else $error("reserved select on divider a advanced counter");

  property p_inverted;
    frame[1] && $past(frame[1]) && ratio[1][spfp_pkg::POL_BIT]
      && $stable(ratio[1]) |-> out_b_o == !pulse[1];
  endproperty
  a_inverted: assert property (p_inverted)
    else $error("inverted pulse not inverted");

  property p_edge_style;
    frame[0] && ratio[0][spfp_pkg::STYLE_BIT] && rise[0]
      && frm_cnt[0] >= last[0] |=> pulse[0];
  endproperty
  a_edge_style: assert property (p_edge_style)
    else $error("edge style pulse not started at boundary");

  property p_mid_style;
    frame[0] && !ratio[0][spfp_pkg::STYLE_BIT] && fall[0]
      && frm_cnt[0] == last[0] |=> pulse[0];
  endproperty
  a_mid_style: assert property (p_mid_style)
    else $error("mid style pulse not started on falling edge");

  property p_aligned;
    $changed(pulse[1]) && $past(frame[1]) && $stable(ratio[1])
      |-> $past(rise[1] || fall[1]);
  endproperty
  a_aligned: assert property (p_aligned)
    else $error("pulse moved without a related clock edge");

  c_clock: cover property (!frame[0] && $rose(out_a_o));
  c_frame_b: cover property (frame[1] && $rose(pulse[1]));
  c_mid: cover property (frame[0] && !ratio[0][19] && $fell(pulse[0]));
  c_read: cover property (reg_rd_i && reg_addr_i == spfp_pkg::ADDR_DIV_B);
endmodule // spfp_top
